// ===== rtl/dei_pkg.sv
// constants, record layouts and carriers for the dual input edge block
package dei_pkg;
   // clock and time base
   localparam int CLK_PERIOD_NS = 10;
   localparam int US_NS         = 1000;
   localparam int CYC_PER_US    = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int NUM_CH        = 2;
   localparam int DLY_W         = 12;
   // record set numbers, record lengths and stamp byte offset
   localparam logic [7:0] SET_DIAG_IRQ_ENABLE   = 8'h00;
   localparam logic [7:0] SET_FILTER    = 8'h01;
   localparam logic [7:0] SET_EDGE_EN   = 8'h80;
   localparam logic [4:0] DIAG_SHORT_N  = 5'h04;
   localparam logic [4:0] DIAG_FULL_N   = 5'h14;
   localparam logic [4:0] BYTE_STAMP    = 5'h10;
   // object indices on the index addressed link
   localparam logic [15:0] IX_DIAG_SHORT = 16'h2F00;
   localparam logic [15:0] IX_DIAG_FULL  = 16'h2F01;
   localparam logic [15:0] IX_DIAG_IRQ_ENABLE    = 16'h3100;
   localparam logic [15:0] IX_CH0_DLY    = 16'h3101;
   localparam logic [15:0] IX_CH1_DLY    = 16'h3102;
   localparam logic [15:0] IX_RISE_EN    = 16'h3103;
   localparam logic [15:0] IX_FALL_EN    = 16'h3104;
   // parameter codes and reset values
   localparam logic [7:0] DIAG_IRQ_ENABLE_OFF   = 8'h00;
   localparam logic [7:0] DIAG_IRQ_ENABLE_ON    = 8'h40;
   localparam logic [7:0] DLY_1US       = 8'h00;
   localparam logic [7:0] DLY_3US       = 8'h02;
   localparam logic [7:0] DLY_10US      = 8'h04;
   localparam logic [7:0] DLY_86US      = 8'h07;
   localparam logic [7:0] DLY_342US     = 8'h09;
   localparam logic [7:0] DLY_2731US    = 8'h0C;
   localparam logic [7:0] EDGE_EN_RST   = 8'h00;
   // fixed diagnostic bytes
   localparam logic [7:0] MODULE_CLASS  = 8'h1F;
   localparam logic [7:0] CHANNEL_KIND  = 8'h70;
   localparam logic [7:0] DIAG_BITS_CH  = 8'h00;
   localparam logic [7:0] CHANNEL_COUNT = 8'h02;
   // bit positions
   localparam int ERR_MOD_FAIL = 0;
   localparam int ERR_EXTERNAL = 2;
   localparam int ERR_CHANNEL  = 3;
   localparam int ERR_BUF_OVF  = 3;
   localparam int ERR_PI_LOST  = 6;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic        by_index;
      logic [7:0]  record_set_number;
      logic [15:0] object_index;
      logic [4:0]  byte_sel;
      logic [7:0]  wdata;
   } dei_rec_req_type;

   typedef struct packed {
      logic [7:0]  edge_source_flags;
      logic [7:0]  input_state_snapshot;
      logic [15:0] edge_time_stamp_low;
   } dei_pi_rec_type;
endpackage

// ===== rtl/dei_edge_diag.sv
// two channel filtered input, edge interrupts and diagnostic record
`timescale 1ns/1ps
// Operation
// - diag enable byte: 00h off, 40h on
// - filter code picks delay, default 02h
// - rising edge enable bits per input
// - falling edge enable bits per input
// - filters set 01h, edges 80h, diag 00h
// - record byte one flags edged inputs
// - record byte two holds input states
// - free running 32 bit microsecond ticker
// - record stamp is ticker low half
// - incoming then automatic going diag interrupt
// - channel events during diag window discarded
// - fault lamp lit during diag window
// - first diag byte: failure, external, channel
// - overflow and lost interrupt always diagnose
// - module class byte reads 1Fh
// - fixed channel count, bits, kind bytes
// - full record set 01h, short 00h
// - index link sends emergency message
// - lost edge flags per input
module dei_edge_diag
   import dei_pkg::*;
#(
   parameter int CYC_US = dei_pkg::CYC_PER_US
)
(
   // clock and reset
   input  wire logic                   core_clk_i,
   input  wire logic                   rst_n_i,
   // field inputs
   input  wire logic [1:0]             input_channel_i,
   // internal fault sources
   input  wire logic                   mod_fail_i,
   input  wire logic                   ext_err_i,
   input  wire logic                   diag_buf_ovf_i,
   // link kind: high on the index addressed link
   input  wire logic                   index_link_i,
   // record access
   input  wire dei_pkg::dei_rec_req_type rec_req_i,
   output logic [7:0]                  rec_rdata_o,
   output logic                        rec_ack_o,
   output logic                        rec_err_o,
   // process interrupt
   input  wire logic                   pi_ack_i,
   output logic                        pi_pending_o,
   output logic                        pi_as_emergency_o,
   output dei_pkg::dei_pi_rec_type     pi_rec_o,
   // diagnostic interrupt
   input  wire logic                   diag_ack_i,
   output logic                        diag_irq_o,
   output logic                        diag_going_o,
   output logic                        module_fault_lamp_o,
   // ticker
   output logic [31:0]                 us_ticker_o
);
   import dei_pkg::*;

   function automatic logic [DLY_W-1:0] dly_us(input logic [7:0] code);
      unique case (code)
         DLY_1US:    dly_us = 12'h001;
         DLY_3US:    dly_us = 12'h003;
         DLY_10US:   dly_us = 12'h00A;
         DLY_86US:   dly_us = 12'h056;
         DLY_342US:  dly_us = 12'h156;
         DLY_2731US: dly_us = 12'hAAB;
         default:    dly_us = 12'h000;
      endcase
   endfunction

   function automatic logic code_ok(input logic [7:0] code);
      code_ok = (dly_us(code) != 12'h000);
   endfunction

   logic [7:0]  diag_irq_enable_reg;
   logic [7:0]  filter_delay_sel_reg [NUM_CH];
   logic [7:0]  rising_edge_irq_enable_reg;
   logic [7:0]  falling_edge_irq_enable_reg;
   logic [6:0]  prescale_reg;
   logic        us_tick;
   logic [DLY_W-1:0] stable_cnt_reg [NUM_CH];
   logic [1:0]  filt_reg;
   logic [1:0]  filt_prev_reg;
   logic [1:0]  edge_hit;
   logic        pi_lost_reg;
   logic        buf_ovf_reg;
   logic [7:0]  lost_edge_flags_reg;
   logic        diag_cause;
   logic        diag_active_reg;
   logic [31:0] diag_time_stamp_reg;
   logic [7:0]  module_diag_byte;
   logic [7:0]  buffer_event_diag;
   logic [7:0]  eff_set;
   logic [4:0]  eff_byte;
   logic        map_ok;
   logic [7:0]  rd_byte;
   logic        rd_ok;
   logic        wr_ok;

   // ticker, one microsecond per CYC_US clocks
   assign us_tick = (prescale_reg == 7'(CYC_US - 1));

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         prescale_reg <= 7'h00;
         us_ticker_o  <= 32'h0000_0000;
      end
      else
      begin
         prescale_reg <= us_tick ? 7'h00 : prescale_reg + 7'h01;
         if (us_tick)
            us_ticker_o <= us_ticker_o + 32'h0000_0001;
      end
   end

   // filter: the input must hold its new level for the selected delay
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         filt_reg       <= 2'h0;
         stable_cnt_reg <= '{default: '0};
      end
      else
      begin
         for (int c = 0; c < NUM_CH; c++)
         begin
            if (input_channel_i[c] == filt_reg[c])
               stable_cnt_reg[c] <= '0;
            else if (us_tick)
            begin
               if (stable_cnt_reg[c] + 12'h001 >=
                   dly_us(filter_delay_sel_reg[c]))
               begin
                  filt_reg[c]       <= input_channel_i[c];
                  stable_cnt_reg[c] <= '0;
               end
               else
                  stable_cnt_reg[c] <= stable_cnt_reg[c] + 12'h001;
            end
         end
      end
   end

   // edges come from the filtered level only
   assign edge_hit =
      (filt_reg & ~filt_prev_reg & rising_edge_irq_enable_reg[1:0]) |
      (~filt_reg & filt_prev_reg & falling_edge_irq_enable_reg[1:0]);

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         filt_prev_reg <= 2'h0;
      else
         filt_prev_reg <= filt_reg;
   end

   // process interrupt record; ack and new edge together reload it
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pi_pending_o      <= 1'b0;
         pi_rec_o          <= '0;
         pi_as_emergency_o <= 1'b0;
      end
      else
      begin
         pi_as_emergency_o <= index_link_i;
         if (|edge_hit && !diag_active_reg && (!pi_pending_o || pi_ack_i))
         begin
            pi_pending_o <= 1'b1;
            pi_rec_o.edge_source_flags    <= {6'h00, edge_hit};
            pi_rec_o.input_state_snapshot <= {6'h00, filt_reg};
            pi_rec_o.edge_time_stamp_low  <= us_ticker_o[15:0];
         end
         else if (pi_ack_i)
            pi_pending_o <= 1'b0;
      end
   end

   // sticky diagnostic events; a set in the clearing cycle wins
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pi_lost_reg         <= 1'b0;
         buf_ovf_reg         <= 1'b0;
         lost_edge_flags_reg <= 8'h00;
      end
      else
      begin
         pi_lost_reg <= (pi_lost_reg && !diag_ack_i) ||
            (|edge_hit && !diag_active_reg && pi_pending_o &&
             !pi_ack_i);
         buf_ovf_reg <= (buf_ovf_reg && !diag_ack_i) || diag_buf_ovf_i;
         lost_edge_flags_reg <= (diag_ack_i ? 8'h00 : lost_edge_flags_reg) |
            (diag_active_reg ? {6'h00, edge_hit} : 8'h00);
      end
   end

   // overflow and loss diagnose regardless of the enable byte
   assign diag_cause = pi_lost_reg || buf_ovf_reg ||
      (|lost_edge_flags_reg) ||
      ((diag_irq_enable_reg == DIAG_IRQ_ENABLE_ON) &&
       (mod_fail_i || ext_err_i));

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         diag_active_reg     <= 1'b0;
         diag_irq_o          <= 1'b0;
         diag_going_o        <= 1'b0;
         module_fault_lamp_o <= 1'b0;
         diag_time_stamp_reg <= 32'h0000_0000;
      end
      else
      begin
         diag_active_reg     <= diag_cause;
         diag_irq_o          <= diag_cause != diag_active_reg;
         diag_going_o        <= diag_active_reg && !diag_cause;
         module_fault_lamp_o <= diag_cause;
         if (diag_cause && !diag_active_reg)
            diag_time_stamp_reg <= us_ticker_o;
      end
   end

   assign module_diag_byte = {4'h0, |lost_edge_flags_reg, ext_err_i,
                              1'b0, mod_fail_i};
   assign buffer_event_diag = {1'b0, pi_lost_reg, 2'h0, buf_ovf_reg,
                               3'h0};

   // index link addresses map onto record set and byte
   always_comb
   begin
      eff_set  = rec_req_i.record_set_number;
      eff_byte = rec_req_i.byte_sel;
      map_ok   = 1'b1;
      if (rec_req_i.by_index)
      begin
         unique case (rec_req_i.object_index)
            IX_DIAG_SHORT, IX_DIAG_IRQ_ENABLE: eff_set = SET_DIAG_IRQ_ENABLE;
            IX_DIAG_FULL: eff_set = SET_FILTER;
            IX_CH0_DLY:
            begin
               eff_set  = SET_FILTER;
               eff_byte = 5'h00;
            end
            IX_CH1_DLY:
            begin
               eff_set  = SET_FILTER;
               eff_byte = 5'h01;
            end
            IX_RISE_EN:
            begin
               eff_set  = SET_EDGE_EN;
               eff_byte = 5'h00;
            end
            IX_FALL_EN:
            begin
               eff_set  = SET_EDGE_EN;
               eff_byte = 5'h01;
            end
            default: map_ok = 1'b0;
         endcase
         if (rec_req_i.object_index == IX_DIAG_IRQ_ENABLE ||
             rec_req_i.object_index == IX_CH0_DLY ||
             rec_req_i.object_index == IX_CH1_DLY ||
             rec_req_i.object_index == IX_RISE_EN ||
             rec_req_i.object_index == IX_FALL_EN)
            eff_byte = (rec_req_i.object_index == IX_DIAG_IRQ_ENABLE) ? 5'h00
                                                                : eff_byte;
      end
   end

   // read map: sets 00h and 01h return the diagnostic record
   always_comb
   begin
      rd_byte = 8'h00;
      rd_ok   = map_ok;
      if (eff_set == SET_EDGE_EN)
      begin
         rd_byte = (eff_byte == 5'h00) ? rising_edge_irq_enable_reg
                                       : falling_edge_irq_enable_reg;
         rd_ok   = map_ok && eff_byte < 5'h02;
      end
      else if ((eff_set == SET_DIAG_IRQ_ENABLE && eff_byte < DIAG_SHORT_N) ||
               (eff_set == SET_FILTER && eff_byte < DIAG_FULL_N))
      begin
         unique case (eff_byte)
            5'h00: rd_byte = module_diag_byte;
            5'h01: rd_byte = MODULE_CLASS;
            5'h02: rd_byte = 8'h00;
            5'h03: rd_byte = buffer_event_diag;
            5'h04: rd_byte = CHANNEL_KIND;
            5'h05: rd_byte = DIAG_BITS_CH;
            5'h06: rd_byte = CHANNEL_COUNT;
            5'h07: rd_byte = lost_edge_flags_reg;
            5'h10: rd_byte = diag_time_stamp_reg[7:0];
            5'h11: rd_byte = diag_time_stamp_reg[15:8];
            5'h12: rd_byte = diag_time_stamp_reg[23:16];
            5'h13: rd_byte = diag_time_stamp_reg[31:24];
            default: rd_byte = 8'h00;
         endcase
      end
      else
         rd_ok = 1'b0;
   end

   // write map; bad filter codes and stray bytes are refused
   always_comb
   begin
      wr_ok = 1'b0;
      if (map_ok)
      begin
         unique case (eff_set)
            SET_DIAG_IRQ_ENABLE: wr_ok = eff_byte == 5'h00 &&
               (rec_req_i.wdata == DIAG_IRQ_ENABLE_OFF ||
                rec_req_i.wdata == DIAG_IRQ_ENABLE_ON);
            SET_FILTER:  wr_ok = eff_byte < 5'h02 &&
               code_ok(rec_req_i.wdata);
            SET_EDGE_EN: wr_ok = eff_byte < 5'h02;
            default:     wr_ok = 1'b0;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         diag_irq_enable_reg         <= DIAG_IRQ_ENABLE_OFF;
         filter_delay_sel_reg        <= '{default: DLY_3US};
         rising_edge_irq_enable_reg  <= EDGE_EN_RST;
         falling_edge_irq_enable_reg <= EDGE_EN_RST;
      end
      else if (rec_req_i.wr && wr_ok)
      begin
         unique case (eff_set)
            SET_DIAG_IRQ_ENABLE: diag_irq_enable_reg <= rec_req_i.wdata;
            SET_FILTER:
               filter_delay_sel_reg[eff_byte[0]] <= rec_req_i.wdata;
            default:
               if (eff_byte == 5'h00)
                  rising_edge_irq_enable_reg <=
                     {6'h00, rec_req_i.wdata[1:0]};
               else
                  falling_edge_irq_enable_reg <=
                     {6'h00, rec_req_i.wdata[1:0]};
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rec_ack_o   <= 1'b0;
         rec_err_o   <= 1'b0;
         rec_rdata_o <= 8'h00;
      end
      else
      begin
         rec_ack_o   <= rec_req_i.wr || rec_req_i.rd;
         rec_err_o   <= (rec_req_i.wr && !wr_ok) ||
                        (rec_req_i.rd && !rec_req_i.wr && !rd_ok);
         rec_rdata_o <= (rec_req_i.rd && rd_ok) ? rd_byte : 8'h00;
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_edge_free;
      |edge_hit && !diag_active_reg && !pi_pending_o;
   endsequence
   sequence s_cause_rise;
      diag_cause && !diag_active_reg;
   endsequence

   AST_DIAG_IRQ_ENABLE_GATE: assert property (
      (mod_fail_i && diag_irq_enable_reg == DIAG_IRQ_ENABLE_OFF && !pi_lost_reg &&
       !buf_ovf_reg && lost_edge_flags_reg == 8'h00) |-> !diag_cause)
      else $error("fault diagnosed while disabled");
   AST_FILTER_CODE: assert property (
      rec_req_i.wr && eff_set == SET_FILTER && !code_ok(rec_req_i.wdata)
      |=> rec_err_o && $stable(filter_delay_sel_reg[0]))
      else $error("illegal filter code accepted");
   AST_TICK: assert property (
      us_tick |=> us_ticker_o == $past(us_ticker_o) + 32'h0000_0001)
      else $error("ticker did not advance");
   AST_PI_CAPTURE: assert property (
      s_edge_free |=> pi_pending_o &&
      pi_rec_o.edge_source_flags == {6'h00, $past(edge_hit)} &&
      pi_rec_o.edge_time_stamp_low == $past(us_ticker_o[15:0]))
      else $error("process record not captured");
   AST_PI_STATE: assert property (
      s_edge_free |=> pi_rec_o.input_state_snapshot[1:0] == $past(filt_reg))
      else $error("input state snapshot wrong");
   AST_PI_LOST: assert property (
      |edge_hit && !diag_active_reg && pi_pending_o && !pi_ack_i
      |=> pi_lost_reg && $stable(pi_rec_o))
      else $error("pending record overwritten");
   AST_DISCARD: assert property (
      |edge_hit && diag_active_reg && !pi_pending_o |=> !pi_pending_o)
      else $error("event stored inside diag window");
   AST_INCOMING: assert property (
      s_cause_rise |=> diag_irq_o && !diag_going_o && diag_active_reg)
      else $error("incoming diag interrupt missing");
   AST_LAMP: assert property (
      (pi_lost_reg && $past(pi_lost_reg)) ||
      (buf_ovf_reg && $past(buf_ovf_reg)) |-> module_fault_lamp_o)
      else $error("fault lamp dark in diag window");
   AST_STAMP: assert property (
      s_cause_rise |=> diag_time_stamp_reg == $past(us_ticker_o))
      else $error("diag stamp not taken");
endmodule

// ===== test/dei_coupler_model.sv
// far side coupler model: takes process records and diagnostic interrupts
`timescale 1ns/1ps
module dei_coupler_model
#(
   parameter int ACK_LAT = 3
)
(
   // clock and reset
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   // stall control from the bench
   input  wire logic hold_i,
   // device side
   input  wire logic pi_pending_i,
   input  wire logic diag_irq_i,
   input  wire logic diag_going_i,
   output logic      pi_ack_o,
   output logic      diag_ack_o
);
   int   wait_reg;
   logic diag_seen_reg;

   // a held coupler leaves records waiting, as a busy backplane would
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wait_reg      <= 0;
         diag_seen_reg <= 1'b0;
         pi_ack_o      <= 1'b0;
         diag_ack_o    <= 1'b0;
      end
      else
      begin
         pi_ack_o   <= 1'b0;
         diag_ack_o <= 1'b0;
         if (diag_irq_i && !diag_going_i)
            diag_seen_reg <= 1'b1;
         if (hold_i || pi_ack_o || diag_ack_o ||
             (!pi_pending_i && !diag_seen_reg))
            wait_reg <= 0;
         else if (wait_reg == ACK_LAT)
         begin
            wait_reg      <= 0;
            pi_ack_o      <= pi_pending_i;
            diag_ack_o    <= diag_seen_reg;
            diag_seen_reg <= 1'b0;
         end
         else
            wait_reg <= wait_reg + 1;
      end
   end
endmodule

// ===== test/tb_top.sv
// self-checking bench for the dual input edge block
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
         err_total++; \
         $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module tb_top;
   import dei_pkg::*;
   // short microsecond keeps filter delays to a few cycles
   localparam int         CYC = 4;
   localparam logic       N   = 1'b0;
   localparam logic       Y   = 1'b1;
   localparam logic [7:0] Z8  = 8'h00;
   localparam logic [4:0] Z5  = 5'h00;
   typedef struct packed {
      logic       chk_d;
      logic [7:0] d;
      logic       e;
   } dei_exp_type;
   logic            clk;
   logic            rst_n;
   logic [1:0]      din;
   logic            mod_fail;
   logic            ext_err;
   logic            ovf;
   logic            idx_link;
   logic            hold;
   dei_rec_req_type req;
   logic [7:0]      rdata;
   logic            ack;
   logic            err;
   logic            pi_ack;
   logic            pend;
   logic            emerg;
   dei_pi_rec_type  pi_rec;
   logic            diag_ack;
   logic            irq;
   logic            going;
   logic            lamp;
   logic [31:0]     tick;
   dei_exp_type     exp_q[$];
   dei_exp_type     note;
   int              err_total;
   int              n_tests;
   logic [7:0]      id_tbl [16];
   logic [7:0]      dly_tbl [6];
   logic [7:0]      bad;
   logic [31:0]     t0;

   dei_edge_diag #(.CYC_US(CYC)) DUT (.core_clk_i(clk), .rst_n_i(rst_n),
      .input_channel_i(din), .mod_fail_i(mod_fail), .ext_err_i(ext_err),
      .diag_buf_ovf_i(ovf), .index_link_i(idx_link), .rec_req_i(req),
      .rec_rdata_o(rdata), .rec_ack_o(ack), .rec_err_o(err),
      .pi_ack_i(pi_ack), .pi_pending_o(pend), .pi_as_emergency_o(emerg),
      .pi_rec_o(pi_rec), .diag_ack_i(diag_ack), .diag_irq_o(irq),
      .diag_going_o(going), .module_fault_lamp_o(lamp),
      .us_ticker_o(tick));

   dei_coupler_model u_cpl (.core_clk_i(clk), .rst_n_i(rst_n),
      .hold_i(hold), .pi_pending_i(pend), .diag_irq_i(irq),
      .diag_going_i(going), .pi_ack_o(pi_ack), .diag_ack_o(diag_ack));

   initial clk = 1'b0;
   always #5 clk = ~clk;

   task automatic stop_test();
      $display("counts: %0d compares, %0d mismatches", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic tend(input string name);
      $display("test %s done", name);
   endtask

   task automatic acc(input logic w, input logic ix, input logic [15:0] a,
                      input logic [4:0] b, input logic [7:0] wd,
                      input logic [7:0] ed, input logic ee);
      @(negedge clk);
      req.wr = w;
      req.rd = !w;
      req.by_index = ix;
      req.object_index = a;
      req.record_set_number = a[7:0];
      req.byte_sel = b;
      req.wdata = wd;
      exp_q.push_back('{!w, ed, ee});
      @(negedge clk);
      req = '0;
   endtask

   task automatic wait_pi(input logic [7:0] src, input logic [7:0] st);
      int k;
      k = 0;
      do
      begin
         @(negedge clk);
         k++;
      end
      while (pend !== 1'b1 && k < 200);
      `CHK(pend, Y)
      `CHK(pi_rec.edge_source_flags, src)
      `CHK(pi_rec.input_state_snapshot, st)
      `CHK((tick[15:0] - pi_rec.edge_time_stamp_low) <= 16'h0001, Y)
      @(negedge clk);
   endtask

   task automatic wait_irq(input logic exp_going);
      int k;
      k = 0;
      do
      begin
         @(negedge clk);
         k++;
      end
      while (irq !== 1'b1 && k < 200);
      `CHK(irq, Y)
      `CHK(going, exp_going)
      `CHK(lamp, !exp_going)
      @(negedge clk);
   endtask

   task automatic quiet();
      repeat (40) @(negedge clk);
      `CHK(pend, N)
      @(negedge clk);
   endtask

   // answers come back in request order, one per ack; read mid cycle
   always @(negedge clk)
   begin
      if (rst_n === 1'b1 && ack === 1'b1)
      begin
         if (exp_q.size() == 0)
         begin
            err_total++;
            $display("mismatch at %0t: unexpected answer", $time);
         end
         else
         begin
            note = exp_q.pop_front();
            `CHK(err, note.e)
            if (note.chk_d)
               `CHK(rdata, note.d)
         end
      end
   end

   initial
   begin
      // tests need a few hundred cycles; allow ample margin
      #200_000;
      err_total++;
      $display("mismatch at %0t: watchdog expired", $time);
      stop_test();
   end

   initial
   begin
      rst_n = N;
      din = 2'b00;
      mod_fail = N;
      ext_err = N;
      ovf = N;
      idx_link = N;
      hold = N;
      req = '0;
      err_total = 0;
      n_tests = 0;
      id_tbl = '{Z8, MODULE_CLASS, Z8, Z8, CHANNEL_KIND, DIAG_BITS_CH,
                 CHANNEL_COUNT, Z8, Z8, Z8, Z8, Z8, Z8, Z8, Z8, Z8};
      dly_tbl = '{DLY_2731US, DLY_342US, DLY_86US, DLY_10US, DLY_3US,
                  DLY_1US};
      void'($urandom(72));
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst_n = Y;
      for (int i = 0; i < 16; i++)
         acc(N, N, 16'h0001, 5'(i), Z8, id_tbl[i], N);
      for (int i = 0; i < 4; i++)
         acc(N, N, 16'h0000, 5'(i), Z8, id_tbl[i], N);
      acc(N, N, 16'h0000, 5'h04, Z8, Z8, Y);
      acc(N, Y, IX_DIAG_SHORT, 5'h01, Z8, MODULE_CLASS, N);
      acc(N, Y, IX_DIAG_FULL, 5'h06, Z8, CHANNEL_COUNT, N);
      acc(N, N, 16'h0005, Z5, Z8, Z8, Y);
      tend("ident");
      // system stopped: parameter sets may be sent
      bad = 8'($urandom());
      if (bad == DIAG_IRQ_ENABLE_OFF || bad == DIAG_IRQ_ENABLE_ON)
         bad = 8'h41;
      acc(Y, N, 16'(SET_DIAG_IRQ_ENABLE), Z5, bad, Z8, Y);
      foreach (dly_tbl[i])
      begin
         acc(Y, N, 16'(SET_FILTER), 5'h00, dly_tbl[i], Z8, N);
         acc(Y, N, 16'(SET_FILTER), 5'h01, dly_tbl[i], Z8, N);
      end
      acc(Y, N, 16'(SET_FILTER), 5'h00, 8'h05, Z8, Y);
      acc(Y, Y, IX_RISE_EN, Z5, 8'h01, Z8, N);
      acc(Y, Y, IX_FALL_EN, Z5, 8'h02, Z8, N);
      tend("params");
      din = 2'b01;
      wait_pi(8'h01, 8'h01);
      din = 2'b11;
      quiet();
      din = 2'b10;
      quiet();
      din = 2'b00;
      wait_pi(8'h02, 8'h00);
      for (int i = 1; i >= 0; i--)
      begin
         idx_link = 1'(i);
         repeat (3) @(negedge clk);
         `CHK(emerg, 1'(i))
         @(negedge clk);
      end
      tend("edges");
      acc(Y, N, 16'(SET_EDGE_EN), 5'h00, 8'h03, Z8, N);
      acc(Y, N, 16'(SET_EDGE_EN), 5'h01, 8'h03, Z8, N);
      hold = Y;
      din = 2'b01;
      wait_pi(8'h01, 8'h01);
      din = 2'b00;
      wait_irq(N);
      din = 2'b10;
      repeat (40) @(posedge clk);
      `CHK(pi_rec.edge_source_flags, 8'h01)
      acc(N, N, 16'h0001, 5'h03, Z8, 8'h40, N);
      acc(N, N, 16'h0001, 5'h07, Z8, 8'h02, N);
      hold = N;
      wait_irq(Y);
      acc(N, N, 16'h0001, 5'h03, Z8, Z8, N);
      acc(N, N, 16'h0001, 5'h07, Z8, Z8, N);
      din = 2'b00;
      wait_pi(8'h02, 8'h00);
      tend("lost");
      hold = Y;
      ovf = Y;
      @(negedge clk);
      ovf = N;
      wait_irq(N);
      acc(N, N, 16'h0001, 5'h03, Z8, 8'h08, N);
      hold = N;
      wait_irq(Y);
      mod_fail = Y;
      repeat (30) @(posedge clk);
      `CHK(lamp, N)
      @(negedge clk);
      mod_fail = N;
      acc(Y, N, 16'(SET_DIAG_IRQ_ENABLE), Z5, DIAG_IRQ_ENABLE_ON, Z8, N);
      for (int i = 0; i < 2; i++)
      begin
         mod_fail = (i == 0);
         ext_err = (i == 1);
         wait_irq(N);
         acc(N, N, 16'h0000, Z5, Z8, (i == 0) ? 8'h01 : 8'h04, N);
         mod_fail = N;
         ext_err = N;
         wait_irq(Y);
      end
      tend("diag");
      // 10 us filter: no record well before the delay has run out
      acc(Y, N, 16'(SET_FILTER), 5'h00, DLY_10US, Z8, N);
      din = 2'b01;
      repeat (30) @(negedge clk);
      `CHK(pend, N)
      wait_pi(8'h01, 8'h01);
      tend("delay");
      @(negedge clk);
      t0 = tick;
      repeat (4 * CYC) @(negedge clk);
      `CHK(tick - t0, 32'h0000_0004)
      repeat (5) @(negedge clk);
      tend("ticker");
      `CHK(exp_q.size(), 0)
      stop_test();
   end
endmodule
